/* File: hdl/acsr_top.sv */
// Chosen here: the APB register port and the register addresses.
`include "acsr_regs.svh"

module acsr_top #(
   parameter int E_DIV = `ACSR_E_DIV
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cmp_above,
   output acsr_pkg::acsr_front_s front
);
   import acsr_pkg::*;

   localparam logic [5:0] SAMPLE_END = `ACSR_LEAD_TICKS
      + `ACSR_SAMPLE_TICKS - 6'd1;
   localparam logic [5:0] CONV_END = `ACSR_LEAD_TICKS
      + `ACSR_CONV_TICKS - 6'd1;
   localparam logic [4:0] DIV_LAST = 5'(E_DIV - 1);
   localparam int CONV_MCLK = 32 * E_DIV;

   ////////////////////////////////////////////////////////////////////////
   // state

   logic [5:0] ctrl;
   logic conversions_complete_flag;
   acsr_state_e state;
   logic [4:0] div_cnt;
   logic e_tick;
   logic [5:0] tick;
   logic [1:0] conv_idx;
   acsr_result_t sar;
   acsr_result_t mask;
   logic pend;
   logic [1:0] pend_slot;
   acsr_result_t pend_data;
   acsr_result_t res [4];
   logic [3:0] valid;

   logic access;
   logic done;
   logic ctrl_wr;
   logic hit_ctrl;
   logic hit_res;
   logic [1:0] res_idx;
   logic conv_end;
   logic xfer;
   acsr_front_s next_front;

   ////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state so read data comes from a flop

   assign access = psel && penable;
   assign done = access && pready;

   always_comb begin
      hit_ctrl = 1'b0;
      hit_res = 1'b1;
      res_idx = 2'd0;
      case (paddr)
         `ACSR_CTRL_OFS: begin
            hit_ctrl = 1'b1;
            hit_res = 1'b0;
         end
         `ACSR_RES1_OFS: res_idx = 2'd0;
         `ACSR_RES2_OFS: res_idx = 2'd1;
         `ACSR_RES3_OFS: res_idx = 2'd2;
         `ACSR_RES4_OFS: res_idx = 2'd3;
         default: hit_res = 1'b0;
      endcase
   end

   assign ctrl_wr = done && pwrite && hit_ctrl;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= access && !pready;
      end
   end

   // writes to results answer with an error and change nothing
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access && !pready) begin
         prdata <= 32'h0000_0000;
         pslverr <= !(hit_ctrl || (hit_res && !pwrite));
         if (hit_ctrl && !pwrite) begin
            prdata[7:0] <= {conversions_complete_flag, 1'b0, ctrl};
         end else if (hit_res && !pwrite) begin
            prdata[7:0] <= res[res_idx];
         end
      end else begin
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `ACSR_CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl <= pwdata[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // e clock enable from mclk

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 5'd0;
         e_tick <= 1'b0;
      end else if (div_cnt == DIV_LAST) begin
         div_cnt <= 5'd0;
         e_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 5'd1;
         e_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer: four conversions of 32 e ticks each, 34 for the first one after a write

   assign conv_end = (state == ACSR_RUN) && e_tick && (tick == CONV_END);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ACSR_IDLE;
         tick <= 6'd0;
         conv_idx <= 2'd0;
      end else if (ctrl_wr) begin
         // a write aborts whatever runs and starts over
         state <= ACSR_RUN;
         tick <= 6'd0;
         conv_idx <= 2'd0;
      end else begin
         case (state)
            ACSR_RUN: begin
               if (conv_end) begin
                  tick <= `ACSR_LEAD_TICKS;
                  conv_idx <= conv_idx + 2'd1;
                  if (conv_idx == 2'd3 && !ctrl[`ACSR_SCAN_BIT]) begin
                     state <= ACSR_IDLE;
                  end
               end else if (e_tick) begin
                  tick <= tick + 6'd1;
               end
            end
            default: begin
               tick <= 6'd0;
            end
         endcase
      end
   end

   // successive approximation, msb first
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sar <= 8'h00;
         mask <= 8'h00;
      end else if (ctrl_wr) begin
         sar <= 8'h00;
         mask <= 8'h00;
      end else if (state == ACSR_RUN && e_tick) begin
         if (tick == SAMPLE_END) begin
            sar <= 8'h80;
            mask <= 8'h80;
         end else if (mask != 8'h00) begin
            sar <= (cmp_above ? sar : (sar & ~mask)) | (mask >> 1);
            mask <= mask >> 1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result transfer, held back while the bus is busy

   assign xfer = pend && !psel;

   // slot equals conversion order, and in group mode the low code bits too
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= 1'b0;
         pend_slot <= 2'd0;
         pend_data <= 8'h00;
      end else if (ctrl_wr) begin
         pend <= 1'b0;
      end else if (conv_end) begin
         pend <= 1'b1;
         pend_slot <= conv_idx;
         pend_data <= sar;
      end else if (xfer) begin
         pend <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            res[i] <= 8'h00;
         end
      end else if (xfer) begin
         res[pend_slot] <= pend_data;
      end
   end

   // xfer needs psel low and ctrl_wr psel high, so they never meet
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         valid <= 4'h0;
         conversions_complete_flag <= 1'b0;
      end else if (ctrl_wr) begin
         valid <= 4'h0;
         conversions_complete_flag <= 1'b0;
      end else if (xfer) begin
         valid[pend_slot] <= 1'b1;
         if ((valid | (4'h1 << pend_slot)) == 4'hF) begin
            conversions_complete_flag <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channel decode toward the analog front end

   always_comb begin
      next_front = '0;
      next_front.sample = (state == ACSR_RUN)
         && tick >= `ACSR_LEAD_TICKS && tick <= SAMPLE_END;
      if (ctrl[`ACSR_GROUP_BIT]) begin
         next_front.chan = {ctrl[3:2], conv_idx};
      end else begin
         next_front.chan = ctrl[3:0];
      end
      if (!next_front.chan[3]) begin
         next_front.pin_sel = 8'h01 << next_front.chan[2:0];
      end
      // 10xx and 1111 leave every input open
      next_front.high_ref_sel = next_front.chan == `ACSR_CH_HIGH_REF;
      next_front.low_ref_sel = next_front.chan == `ACSR_CH_LOW_REF;
      // no divider: capacitor wiring during sample fakes half reference
      next_front.half_ref_sample = next_front.sample
         && next_front.chan == `ACSR_CH_HALF_REF;
      next_front.dac_trial = sar;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         front <= '0;
      end else begin
         front <= next_front;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic [10:0] gap;
   logic first_conv;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gap <= 11'd0;
         first_conv <= 1'b1;
      end else if (ctrl_wr) begin
         gap <= 11'd0;
         first_conv <= 1'b1;
      end else if (conv_end) begin
         gap <= 11'd0;
         first_conv <= 1'b0;
      end else if (gap != 11'h7FF) begin
         gap <= gap + 11'd1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // checked against the control word, not the decoded channel
   pin_decode_a: assert property (
      !ctrl[`ACSR_GROUP_BIT] && !ctrl[3] && !ctrl_wr
      |=> front.pin_sel == (8'h01 << $past(ctrl[2:0])))
      else $error("pin select does not match channel code");

   group_sel_a: assert property (
      ctrl[`ACSR_GROUP_BIT] && !ctrl_wr
      |=> front.chan == {$past(ctrl[3:2]), $past(conv_idx)})
      else $error("group mode channel wrong");

   single_sel_a: assert property (
      !ctrl[`ACSR_GROUP_BIT] && !ctrl_wr |=> front.chan == $past(ctrl[3:0]))
      else $error("single mode channel wrong");

   reserved_a: assert property (
      front.chan[3:2] == 2'b10 |-> front.pin_sel == 8'h00
      && !front.high_ref_sel && !front.low_ref_sel)
      else $error("reserved code selected an input");

   half_ref_a: assert property (
      front.half_ref_sample |-> front.sample
      && front.chan == `ACSR_CH_HALF_REF && front.pin_sel == 8'h00)
      else $error("half reference strobe outside its sample");

   no_upd_read_a: assert property (
      psel |=> res[0] == $past(res[0]) && res[1] == $past(res[1])
      && res[2] == $past(res[2]) && res[3] == $past(res[3]))
      else $error("result changed during a bus transfer");

   slot_fill_a: assert property (
      xfer |=> valid[$past(pend_slot)] && res[$past(pend_slot)]
      == $past(pend_data))
      else $error("result landed in wrong slot");

   done_flag_a: assert property (
      $rose(conversions_complete_flag) |-> valid == 4'hF)
      else $error("complete flag set with a result missing");

   write_restart_a: assert property (
      ctrl_wr |=> !conversions_complete_flag && state == ACSR_RUN
      && tick == 6'd0 && valid == 4'h0 && !pend)
      else $error("control write did not restart");

   revisit_rate_a: assert property (
      conv_end && !first_conv |-> gap == 11'(CONV_MCLK - 1))
      else $error("conversion spacing wrong");

   stop_single_a: assert property (
      conv_end && conv_idx == 2'd3 && !ctrl[`ACSR_SCAN_BIT] && !ctrl_wr
      |=> state == ACSR_IDLE)
      else $error("single pass did not stop");

   scan_wrap_c: cover property (
      conv_end && conv_idx == 2'd3 && ctrl[`ACSR_SCAN_BIT]);
   done_flag_c: cover property ($rose(conversions_complete_flag));
   held_xfer_c: cover property (pend && psel ##1 xfer);
   half_ref_c: cover property ($rose(front.half_ref_sample));

endmodule : acsr_top

/* File: hdl/acsr_regs.svh */
`ifndef ACSR_REGS_SVH
`define ACSR_REGS_SVH

// register byte offsets on the apb
`define ACSR_CTRL_OFS 12'h000
`define ACSR_RES1_OFS 12'h004
`define ACSR_RES2_OFS 12'h008
`define ACSR_RES3_OFS 12'h00C
`define ACSR_RES4_OFS 12'h010

// control/status field positions
`define ACSR_DONE_FLAG_BIT 7
`define ACSR_SCAN_BIT 5
`define ACSR_GROUP_BIT 4
`define ACSR_CTRL_RST 6'h00

// channel codes of the test inputs
`define ACSR_CH_HIGH_REF 4'hC
`define ACSR_CH_LOW_REF 4'hD
`define ACSR_CH_HALF_REF 4'hE

// timing: ns figures, e clock ticks
`define ACSR_MCLK_NS 20
`define ACSR_E_NS 500
`define ACSR_E_DIV (`ACSR_E_NS / `ACSR_MCLK_NS)
`define ACSR_LEAD_TICKS 6'd2
`define ACSR_SAMPLE_TICKS 6'd12
`define ACSR_CONV_TICKS 6'd32

`endif

/* File: hdl/acsr_pkg.sv */
package acsr_pkg;

   typedef enum logic [0:0] {
      ACSR_IDLE = 1'b0,
      ACSR_RUN = 1'b1
   } acsr_state_e;

   // analog front end steering, all registered
   typedef struct packed {
      logic sample;
      logic [3:0] chan;
      logic [7:0] pin_sel;
      logic high_ref_sel;
      logic low_ref_sel;
      logic half_ref_sample;
      logic [7:0] dac_trial;
   } acsr_front_s;

   typedef logic [7:0] acsr_result_t;

endpackage : acsr_pkg

/* File: sim/acsr_analog_model.sv */
module acsr_analog_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire acsr_pkg::acsr_front_s front,
   output logic cmp_above
);
   timeunit 1ns;
   timeprecision 1ps;
   import acsr_pkg::*;

   logic [7:0] held;
   logic [7:0] pin_lvl;

   ////////////////////////////////////////////////////////////////////////
   // pins sit exactly on their code, 3 plus 29 per pin, and the >= compare makes the sar land on it
   always_comb begin
      pin_lvl = 8'h00;
      for (int k = 0; k < 8; k++) begin
         if (front.pin_sel[k]) begin
            pin_lvl = 8'h03 + 8'(k * 29);
         end
      end
   end

   // charge is captured on every sample cycle, the last one wins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         held <= 8'h00;
      end else if (front.sample) begin
         if (front.half_ref_sample) begin
            held <= 8'h80;
         end else if (front.high_ref_sel) begin
            held <= 8'hFF;
         end else if (front.low_ref_sel) begin
            held <= 8'h00;
         end else if (front.pin_sel != 8'h00) begin
            held <= pin_lvl;
         end else begin
            // nothing selected: floating input, value is meaningless
            held <= ~held;
         end
      end
   end

   assign cmp_above = (held >= front.dac_trial);

endmodule : acsr_analog_model

/* File: sim/tb_top.sv */
`include "acsr_regs.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import acsr_pkg::*;

   localparam int EDIV = 5;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, cmp_above;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   acsr_front_s front;
   int bad_count, checked;
   int cyc = 0;
   int nsamp = 0;
   logic smp_q = 1'b0;

   acsr_top #(.E_DIV(EDIV)) i_acsr_top (.mclk(mclk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_above(cmp_above), .front(front));
   acsr_analog_model i_acsr_analog_model (.mclk(mclk), .rst_n(rst_n),
      .front(front), .cmp_above(cmp_above));

   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      smp_q <= front.sample;
      if (front.sample && !smp_q) begin
         nsamp <= nsamp + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) chk("pready", 1, 0);
   endtask : apb

   task automatic rd(input string what, input logic [11:0] a,
         input logic [31:0] exp, input logic ee);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(what, exp, r);
      chk(what, {31'h0, ee}, {31'h0, e});
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic ee);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk("write err", {31'h0, ee}, {31'h0, e});
   endtask : wr

   task automatic wait_done();
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      do begin
         apb(1'b0, `ACSR_CTRL_OFS, 32'h0, r, e);
         n++;
      end while (r[7] !== 1'b1 && n < 500);
      chk("done flag", 1, {31'h0, r[7]});
   endtask : wait_done

   // waits for a fresh sample window of channel c
   task automatic wait_samp(input logic [3:0] c, output int t);
      int n;
      n = 0;
      while (front.sample === 1'b1 && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      while (!(front.sample === 1'b1 && front.chan === c) && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      t = cyc;
      if (n >= 2000) chk("sample wait", 1, 0);
   endtask : wait_samp

   function automatic logic [7:0] lvl(input logic [3:0] c);
      if (c == `ACSR_CH_HIGH_REF) return 8'hFF;
      if (c == `ACSR_CH_HALF_REF) return 8'h80;
      if (c[3]) return 8'h00;
      return 8'h03 + 8'(c * 29);
   endfunction : lvl

   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd("ctrl reset", `ACSR_CTRL_OFS, 32'h0, 1'b0);
      rd("res1 reset", `ACSR_RES1_OFS, 32'h0, 1'b0);
      rd("unmapped", 12'h014, 32'h0, 1'b1);
      wr(`ACSR_RES1_OFS, 32'hAA, 1'b1);
      rd("res1 kept", `ACSR_RES1_OFS, 32'h0, 1'b0);
      wr(`ACSR_CTRL_OFS, 32'hFF, 1'b0);
      rd("ctrl bits", `ACSR_CTRL_OFS, 32'h3F, 1'b0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_single();
      int t, s;
      for (int c = 0; c < 16; c++) begin
         wr(`ACSR_CTRL_OFS, 32'(c), 1'b0);
         rd("flag cleared", `ACSR_CTRL_OFS, 32'(c), 1'b0);
         wait_samp(4'(c), t);
         chk("select", {c[3] ? 8'h00 : 8'h01 << c[2:0], c == 12, c == 13,
            c == 14}, {front.pin_sel, front.high_ref_sel,
            front.low_ref_sel, front.half_ref_sample});
         wait_done();
         if (c < 8 || (c > 11 && c < 15)) begin
            for (int i = 0; i < 4; i++) begin
               rd("single res", `ACSR_RES1_OFS + 12'(4 * i),
                  32'(lvl(4'(c))), 1'b0);
            end
         end
         s = nsamp;
         repeat (600) @(posedge mclk);
         chk("stopped", 32'(s), 32'(nsamp));
      end
      $display("test single done");
   endtask : t_single

   task automatic t_group();
      for (int g = 0; g < 4; g++) begin
         wr(`ACSR_CTRL_OFS, 32'h10 | 32'(g * 4 + 3), 1'b0);
         wait_done();
         for (int i = 0; i < 4; i++) begin
            if (g != 2 && !(g == 3 && i == 3)) begin
               rd("group res", `ACSR_RES1_OFS + 12'(4 * i),
                  32'(lvl(4'(g * 4 + i))), 1'b0);
            end
         end
      end
      $display("test group done");
   endtask : t_group

   task automatic t_scan();
      int t1, t2;
      wr(`ACSR_CTRL_OFS, 32'h30, 1'b0);
      wait_samp(4'h1, t1);
      wait_samp(4'h1, t2);
      chk("revisit", 32'(128 * EDIV), 32'(t2 - t1));
      rd("scan flag", `ACSR_CTRL_OFS, 32'hB0, 1'b0);
      rd("scan res2", `ACSR_RES2_OFS, 32'(lvl(4'h1)), 1'b0);
      wr(`ACSR_CTRL_OFS, 32'h0D, 1'b0);
      rd("abort", `ACSR_CTRL_OFS, 32'h0D, 1'b0);
      wait_done();
      rd("abort res1", `ACSR_RES1_OFS, 32'h0, 1'b0);
      rd("abort res4", `ACSR_RES4_OFS, 32'h0, 1'b0);
      $display("test scan done");
   endtask : t_scan

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      bad_count = 0;
      checked = 0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_single();
      t_group();
      t_scan();
      final_report();
   end

   // the tests need about 25k cycles, so this leaves ample margin
   initial begin
      #(20 * 80000);
      bad_count++;
      final_report();
   end

endmodule : tb_top
